/* File: ddmas_cfg.svh */
// Constants of the per-socket distributed DMA slave register block.
// Assumes inclusion by bare name from the design module.
`ifndef DDMAS_CFG_SVH
`define DDMAS_CFG_SVH
`define DDMAS_WIN_BYTES 32'd16
`define DDMAS_OFS_ADDR 4'h0
`define DDMAS_OFS_PAGE 4'h2
`define DDMAS_OFS_COUNT 4'h4
`define DDMAS_OFS_CMDSTAT 4'h8
`define DDMAS_OFS_REQUEST 4'h9
`define DDMAS_OFS_MODE 4'hb
`define DDMAS_OFS_MCLEAR 4'hd
`define DDMAS_OFS_MASK 4'hf
`define DDMAS_CMD_DIS_BIT 2
`define DDMAS_MODE_XFER16_BIT 0
`define DDMAS_RST_ADDR 16'h0000
`define DDMAS_RST_PAGE 8'h00
`define DDMAS_RST_COUNT 16'h0000
`define DDMAS_RST_CMD 1'b0
`define DDMAS_RST_MASK 1'b1
`define DDMAS_RST_BASE 16'h0000
`define DDMAS_STEP8 16'h0001
`define DDMAS_STEP16 16'h0002
`endif

/* File: ddmas_pkg.sv */
// Types of the distributed DMA slave register block.
// Assumes ddmas_cfg.svh sits in the same folder.
package ddmas_pkg;
  // Channel sequencing: one-hot
  typedef enum logic [2:0] {
    DDMAS_IDLE = 3'b001,
    DDMAS_RUN  = 3'b010,
    DDMAS_DONE = 3'b100
  } ddmas_state_type;
endpackage

/* File: ddmas_regs.sv */
// Per-socket distributed DMA slave registers and transfer counters.
// Assumes a PCI-side decoder that presents byte-wide I/O accesses within the 16-byte
// window, and a transfer engine that pulses XFER_DONE_IN per completed data transfer.
//
// Behaviour
// - Decode a 16-byte I/O window at the base from config offset 98h.
// - Reserved locations read zero; writes to them change nothing.
// - Obsolete legacy bits are read-only and have no function.
// - Write at 00h sets start address; read returns current address.
// - 8-bit mode: address on AD15-0, page 7-0 on AD23-16.
// - 16-bit mode: address on AD16-1, AD0 low, page 7-1 on AD23-17.
// - Page byte at 02h is read/write, resets to zero.
// - Write at 04h sets byte count; read returns remaining count.
// - Count drops by one per 8-bit transfer, two per 16-bit.
// - Command bit 2 disables the controller when one; other command bits are ignored.
// - Read at 08h returns status, write at 08h sets command.
// - Status bits 7-4 follow card request, regardless of mask.
// - Status bits 3-0 set at terminal count.
// - Terminal-count bits clear on status read or channel reset.
// - Mask set, the reset value, ignores card requests.
// - Card removal sets the mask automatically.
`timescale 1ns/100ps
`include "ddmas_cfg.svh"

module ddmas_regs (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic [31:0] CFG_BASE_IN,
  input wire logic [31:0] IO_ADDR_IN,
  input wire logic IO_WR_IN,
  input wire logic IO_RD_IN,
  input wire logic [7:0] IO_WDATA_IN,
  input wire logic CARD_DMA_REQUEST_IN,
  input wire logic CARD_PRESENT_IN,
  input wire logic XFER_DONE_IN,
  output logic IO_HIT_OUT,
  output logic [7:0] IO_RDATA_OUT,
  output logic BUS_REQ_OUT,
  output logic [31:0] DMA_AD_OUT
);

  // Pin synchronisers: first stage read only by second
  logic req_meta_reg, req_sync_reg, pres_meta_reg, pres_sync_reg, pres_prev_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      pres_meta_reg <= 1'b0;
      pres_sync_reg <= 1'b0;
      pres_prev_reg <= 1'b0;
    end else begin
      req_meta_reg <= CARD_DMA_REQUEST_IN;
      req_sync_reg <= req_meta_reg;
      pres_meta_reg <= CARD_PRESENT_IN;
      pres_sync_reg <= pres_meta_reg;
      pres_prev_reg <= pres_sync_reg;
    end
  end
  wire logic card_removed = pres_prev_reg & ~pres_sync_reg;

  // Window decode; base aligned to the window size
  logic [31:0] win_ofs;
  logic hit;
  logic [3:0] ofs;
  always_comb begin
    win_ofs = IO_ADDR_IN - {CFG_BASE_IN[31:4], 4'h0};
    hit = (win_ofs < `DDMAS_WIN_BYTES);
    ofs = win_ofs[3:0];
  end
  wire logic wr = IO_WR_IN & hit;
  wire logic rd = IO_RD_IN & hit;

  logic [15:0] base_addr_reg, base_addr_next, cur_addr_reg, cur_addr_next;
  logic [15:0] base_cnt_reg, base_cnt_next, cur_cnt_reg, cur_cnt_next;
  logic [7:0] page_reg, page_next;
  logic cmd_dis_reg, cmd_dis_next, mask_reg, mask_next, x16_reg, x16_next;
  logic tc_reg, tc_next;
  ddmas_pkg::ddmas_state_type state_reg, state_next;
  logic [7:0] rdata_next;
  logic [31:0] ad_next;
  logic mclr, do_xfer;
  logic [15:0] step;

  // Register writes, counting and channel sequencing
  always_comb begin
    base_addr_next = base_addr_reg;
    cur_addr_next = cur_addr_reg;
    base_cnt_next = base_cnt_reg;
    cur_cnt_next = cur_cnt_reg;
    page_next = page_reg;
    cmd_dis_next = cmd_dis_reg;
    mask_next = mask_reg;
    x16_next = x16_reg;
    tc_next = tc_reg;
    state_next = state_reg;
    mclr = wr && (ofs == `DDMAS_OFS_MCLEAR);
    step = x16_reg ? `DDMAS_STEP16 : `DDMAS_STEP8;
    do_xfer = XFER_DONE_IN && (state_reg == ddmas_pkg::DDMAS_RUN);
    // Transfer progress; host write in the same cycle takes priority below
    if (do_xfer) begin
      cur_addr_next = cur_addr_reg + 16'h0001;
      cur_cnt_next = cur_cnt_reg - step;
      if (cur_cnt_reg <= step) begin
        tc_next = 1'b1;
        state_next = ddmas_pkg::DDMAS_DONE;
      end
    end
    unique case (state_reg)
      ddmas_pkg::DDMAS_IDLE: begin
        if (req_sync_reg && !mask_reg && !cmd_dis_reg && cur_cnt_reg != 16'h0000) begin
          state_next = ddmas_pkg::DDMAS_RUN;
        end
      end
      ddmas_pkg::DDMAS_RUN: begin
        if (cmd_dis_reg || mask_reg) begin
          state_next = ddmas_pkg::DDMAS_IDLE;
        end
      end
      ddmas_pkg::DDMAS_DONE: begin
      end
    endcase
    // Status read clears terminal count; a new terminal count in the same cycle wins
    if (rd && ofs == `DDMAS_OFS_CMDSTAT && !(do_xfer && cur_cnt_reg <= step)) begin
      tc_next = 1'b0;
    end
    if (wr) begin
      unique case (ofs)
        `DDMAS_OFS_ADDR: begin
          base_addr_next = {base_addr_reg[15:8], IO_WDATA_IN};
          cur_addr_next = {cur_addr_reg[15:8], IO_WDATA_IN};
          state_next = ddmas_pkg::DDMAS_IDLE;
        end
        4'h1: begin
          base_addr_next = {IO_WDATA_IN, base_addr_reg[7:0]};
          cur_addr_next = {IO_WDATA_IN, cur_addr_reg[7:0]};
          state_next = ddmas_pkg::DDMAS_IDLE;
        end
        `DDMAS_OFS_PAGE: page_next = IO_WDATA_IN;
        `DDMAS_OFS_COUNT: begin
          base_cnt_next = {base_cnt_reg[15:8], IO_WDATA_IN};
          cur_cnt_next = {cur_cnt_reg[15:8], IO_WDATA_IN};
          state_next = ddmas_pkg::DDMAS_IDLE;
        end
        4'h5: begin
          base_cnt_next = {IO_WDATA_IN, base_cnt_reg[7:0]};
          cur_cnt_next = {IO_WDATA_IN, cur_cnt_reg[7:0]};
          state_next = ddmas_pkg::DDMAS_IDLE;
        end
        `DDMAS_OFS_CMDSTAT: cmd_dis_next = IO_WDATA_IN[`DDMAS_CMD_DIS_BIT];
        `DDMAS_OFS_MODE: x16_next = IO_WDATA_IN[`DDMAS_MODE_XFER16_BIT];
        `DDMAS_OFS_MASK: mask_next = IO_WDATA_IN[0];
        default: begin
          // Reserved and write-only-no-state offsets are dropped
        end
      endcase
    end
    if (card_removed) begin
      mask_next = 1'b1;
    end
    if (mclr) begin
      base_addr_next = `DDMAS_RST_BASE;
      cur_addr_next = `DDMAS_RST_ADDR;
      base_cnt_next = `DDMAS_RST_BASE;
      cur_cnt_next = `DDMAS_RST_COUNT;
      page_next = `DDMAS_RST_PAGE;
      cmd_dis_next = `DDMAS_RST_CMD;
      mask_next = `DDMAS_RST_MASK;
      x16_next = 1'b0;
      tc_next = 1'b0;
      state_next = ddmas_pkg::DDMAS_IDLE;
    end
  end

  // Read mux and address phase
  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      unique case (ofs)
        4'h0: rdata_next = cur_addr_reg[7:0];
        4'h1: rdata_next = cur_addr_reg[15:8];
        4'h2: rdata_next = page_reg;
        4'h4: rdata_next = cur_cnt_reg[7:0];
        4'h5: rdata_next = cur_cnt_reg[15:8];
        4'h8: rdata_next = {{4{req_sync_reg}}, {4{tc_reg}}};
        4'hb: rdata_next = {7'h00, x16_reg};
        4'hf: rdata_next = {7'h00, mask_reg};
        default: rdata_next = 8'h00;
      endcase
    end
    if (x16_reg) begin
      ad_next = {8'h00, page_reg[7:1], cur_addr_reg, 1'b0};
    end else begin
      ad_next = {8'h00, page_reg, cur_addr_reg};
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      base_addr_reg <= `DDMAS_RST_BASE;
      cur_addr_reg <= `DDMAS_RST_ADDR;
      base_cnt_reg <= `DDMAS_RST_BASE;
      cur_cnt_reg <= `DDMAS_RST_COUNT;
      page_reg <= `DDMAS_RST_PAGE;
      cmd_dis_reg <= `DDMAS_RST_CMD;
      mask_reg <= `DDMAS_RST_MASK;
      x16_reg <= 1'b0;
      tc_reg <= 1'b0;
      state_reg <= ddmas_pkg::DDMAS_IDLE;
      IO_HIT_OUT <= 1'b0;
      IO_RDATA_OUT <= 8'h00;
      BUS_REQ_OUT <= 1'b0;
      DMA_AD_OUT <= 32'h00000000;
    end else begin
      base_addr_reg <= base_addr_next;
      cur_addr_reg <= cur_addr_next;
      base_cnt_reg <= base_cnt_next;
      cur_cnt_reg <= cur_cnt_next;
      page_reg <= page_next;
      cmd_dis_reg <= cmd_dis_next;
      mask_reg <= mask_next;
      x16_reg <= x16_next;
      tc_reg <= tc_next;
      state_reg <= state_next;
      IO_HIT_OUT <= hit && (IO_RD_IN || IO_WR_IN);
      IO_RDATA_OUT <= rdata_next;
      BUS_REQ_OUT <= (state_next == ddmas_pkg::DDMAS_RUN) && req_sync_reg;
      DMA_AD_OUT <= ad_next;
    end
  end

  property p_tc_stops;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (state_reg == ddmas_pkg::DDMAS_DONE) |-> !BUS_REQ_OUT;
  endproperty
  a_tc_stops: assert property (p_tc_stops) else $error("request after terminal count");

  property p_mask_blocks;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (mask_reg && state_reg == ddmas_pkg::DDMAS_IDLE) |=> state_reg != ddmas_pkg::DDMAS_RUN;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked request serviced");

  property p_removal_masks;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (card_removed && !mclr) |=> mask_reg;
  endproperty
  a_removal_masks: assert property (p_removal_masks) else $error("mask not set on removal");

  property p_count_step;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (do_xfer && !wr && !mclr) |=> cur_cnt_reg == $past(cur_cnt_reg) - $past(step);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_status_read;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (rd && ofs == 4'h8) |=> IO_RDATA_OUT == {{4{$past(req_sync_reg)}}, {4{$past(tc_reg)}}};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status byte wrong");

  property p_tc_clear;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (rd && ofs == 4'h8 && !do_xfer) |=> !tc_reg;
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("terminal count not cleared");

  property p_ad16;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      x16_reg |=> (DMA_AD_OUT[0] == 1'b0) && (DMA_AD_OUT[16:1] == $past(cur_addr_reg));
  endproperty
  a_ad16: assert property (p_ad16) else $error("16-bit address phase wrong");

  property p_reserved_zero;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (rd && (ofs == 4'h3 || ofs == 4'hc || ofs == 4'he)) |=> IO_RDATA_OUT == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");

  // Reserved writes must leave page, base address, base count, command and mode alone
  property p_reserved_write;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (wr && (ofs == 4'h3 || ofs == 4'h6 || ofs == 4'h7 || ofs == 4'ha || ofs == 4'hc
        || ofs == 4'he))
      |=> (page_reg == $past(page_reg)) && (base_addr_reg == $past(base_addr_reg))
        && (base_cnt_reg == $past(base_cnt_reg)) && (cmd_dis_reg == $past(cmd_dis_reg))
        && (x16_reg == $past(x16_reg));
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("reserved write acted");

  // Byte mode puts the full page byte above the address
  property p_ad8;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      !x16_reg |=> DMA_AD_OUT == {8'h00, $past(page_reg), $past(cur_addr_reg)};
  endproperty
  a_ad8: assert property (p_ad8)
    else $error("8-bit address phase wrong");

  // A disabled controller must leave the running state at once
  property p_disable_stops;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      (cmd_dis_reg && state_reg == ddmas_pkg::DDMAS_RUN) |=> state_reg != ddmas_pkg::DDMAS_RUN;
  endproperty
  a_disable_stops: assert property (p_disable_stops)
    else $error("disabled channel kept running");

  // Master clear is a channel reset: terminal count gone, mask back on
  property p_mclr_clears;
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      mclr |=> mask_reg && !tc_reg && (cur_cnt_reg == `DDMAS_RST_COUNT)
        && (state_reg == ddmas_pkg::DDMAS_IDLE);
  endproperty
  a_mclr_clears: assert property (p_mclr_clears)
    else $error("master clear incomplete");

endmodule // ddmas_regs

/* File: ddmas_xfer_model.sv */
// Far-side model: the transfer engine and card that complete granted transfers.
// Assumes one clock shared with the register block; driven by tasks from the bench.
`timescale 1ns/100ps

module ddmas_xfer_model (
  input wire logic clk_in,
  input wire logic bus_req_in,
  output logic xfer_done_out
);
  initial xfer_done_out = 1'b0;

  // One pulse per granted cycle; gap models a slow card
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk_in);
      @(posedge clk_in);
      // No completion without a bus request, as a real engine
      if (bus_req_in) begin
        xfer_done_out <= 1'b1;
        @(posedge clk_in);
        xfer_done_out <= 1'b0;
      end
    end
  endtask
endmodule // ddmas_xfer_model

/* File: tb.sv */
// Self-checking bench for the distributed DMA slave register block.
// Assumes ddmas_regs and ddmas_xfer_model are compiled before this file.
`timescale 1ns/100ps

module tb;
  localparam logic [31:0] BASE = 32'h0000_1c40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] io_addr = 32'h0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic card_req = 1'b0;
  logic card_present = 1'b1;
  logic xfer_done;
  logic io_hit;
  logic [7:0] io_rdata;
  logic bus_req;
  logic [31:0] dma_ad;
  int err_total = 0;
  int samples_checked = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  ddmas_regs dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .CFG_BASE_IN(BASE),
    .IO_ADDR_IN(io_addr), .IO_WR_IN(io_wr), .IO_RD_IN(io_rd), .IO_WDATA_IN(io_wdata),
    .CARD_DMA_REQUEST_IN(card_req), .CARD_PRESENT_IN(card_present),
    .XFER_DONE_IN(xfer_done), .IO_HIT_OUT(io_hit), .IO_RDATA_OUT(io_rdata),
    .BUS_REQ_OUT(bus_req), .DMA_AD_OUT(dma_ad));

  ddmas_xfer_model partner_u (.clk_in(clk), .bus_req_in(bus_req), .xfer_done_out(xfer_done));

  task automatic stop_test();
    $display("err_total=%0d samples_checked=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One byte access; strobe held a single cycle, answer seen after it
  task automatic acc(input logic wr, input logic [4:0] ofs, input logic [7:0] d);
    @(posedge clk);
    io_addr <= BASE + {27'h0, ofs};
    io_wr <= wr;
    io_rd <= !wr;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] ofs, input logic [7:0] exp);
    acc(1'b0, ofs, 8'h00);
    chk({24'h0, io_rdata}, {24'h0, exp});
  endtask

  // Low byte first, then high byte
  task automatic w16(input logic [4:0] ofs, input logic [15:0] v);
    acc(1'b1, ofs, v[7:0]);
    acc(1'b1, ofs + 5'h01, v[15:8]);
  endtask

  // Bounded wait for the bus request level
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (bus_req !== lvl && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30) begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic t_reset_map();
    rd(5'h00, 8'h00);
    rd(5'h02, 8'h00);
    rd(5'h05, 8'h00);
    rd(5'h08, 8'h00);
    rd(5'h0f, 8'h01);
    acc(1'b1, 5'h03, 8'hff);
    rd(5'h03, 8'h00);
    chk({31'h0, io_hit}, 32'h1);
    rd(5'h0c, 8'h00);
    acc(1'b0, 5'h10, 8'h00);
    chk({31'h0, io_hit}, 32'h0);
  endtask

  task automatic t_xfer8();
    acc(1'b1, 5'h02, 8'h5b);
    w16(5'h00, 16'h1234);
    rd(5'h00, 8'h34);
    w16(5'h04, 16'h0003);
    acc(1'b1, 5'h0f, 8'h00);
    @(posedge clk);
    card_req <= 1'b1;
    wait_req(1'b1);
    chk(dma_ad, 32'h005b_1234);
    partner_u.burst(1, 0);
    repeat (2) @(posedge clk);
    rd(5'h04, 8'h02);
    partner_u.burst(2, 3);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, bus_req}, 32'h0);
    rd(5'h08, 8'hff);
    rd(5'h08, 8'hf0);
  endtask

  task automatic t_xfer16();
    acc(1'b1, 5'h0b, 8'h01);
    w16(5'h00, 16'h0100);
    w16(5'h04, 16'h0004);
    wait_req(1'b1);
    chk(dma_ad, {8'h00, 7'h2d, 16'h0100, 1'b0});
    partner_u.burst(1, 0);
    repeat (2) @(posedge clk);
    rd(5'h04, 8'h02);
    partner_u.burst(1, 2);
    repeat (3) @(posedge clk);
    rd(5'h08, 8'hff);
  endtask

  // Master clear after a terminal count; also the read-only mask bits
  task automatic t_mclear();
    w16(5'h04, 16'h0002);
    wait_req(1'b1);
    partner_u.burst(1, 0);
    repeat (2) @(posedge clk);
    acc(1'b1, 5'h0d, 8'h00);
    rd(5'h08, 8'hf0);
    rd(5'h04, 8'h00);
    rd(5'h0f, 8'h01);
    chk(dma_ad, 32'h0000_0000);
    acc(1'b1, 5'h0f, 8'hfe);
    rd(5'h0f, 8'h00);
    acc(1'b1, 5'h0f, 8'hff);
    rd(5'h0f, 8'h01);
  endtask

  task automatic t_mask_cmd();
    w16(5'h04, 16'h0002);
    acc(1'b1, 5'h0f, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, bus_req}, 32'h0);
    rd(5'h08, 8'hf0);
    acc(1'b1, 5'h0f, 8'h00);
    acc(1'b1, 5'h08, 8'h04);
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, bus_req}, 32'h0);
    acc(1'b1, 5'h08, 8'h00);
    wait_req(1'b1);
    rd(5'h08, 8'hf0);
    @(posedge clk);
    card_req <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h08, 8'h00);
    @(posedge clk);
    card_present <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h0f, 8'h01);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_map();
    t_xfer8();
    t_xfer16();
    t_mclear();
    t_mask_cmd();
    stop_test();
  end
endmodule // tb
